//--- hw/cgc_control.sv
// Clock generator control register, interlocks and monitor flag
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "cgc_consts.svh"
module cgc_control #(
   parameter int STARTUP_COUNT = `CGC_XTAL_STARTUP
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire cgc_pkg::cgc_addr_t reg_addr,
   input wire cgc_pkg::cgc_byte_t reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output cgc_pkg::cgc_byte_t reg_rdata,
   input wire logic stop_mode,
   input wire logic keep_running_in_stop,
   input wire logic external_input_option,
   input wire logic crystal_option,
   input wire logic internal_dead,
   input wire logic external_dead,
   input wire logic internal_lock,
   input wire logic external_clock_tick,
   input wire logic [3:0] loop_halving,
   input wire cgc_pkg::cgc_byte_t loop_stage,
   output logic monitor_irq,
   output logic oscillator_src_ext,
   output logic internal_gen_on,
   output logic external_gen_on,
   output logic osc_pin_active,
   output logic [6:0] multiplier_register,
   output cgc_pkg::cgc_byte_t capacitor_adjust_register,
   output logic [3:0] oscillator_halving_count,
   output cgc_pkg::cgc_byte_t oscillator_stage_count
);
   import cgc_pkg::*;

   logic monitor_irq_enable, monitor_fail_flag, monitor_on, clock_select;
   logic internal_gen_enable, internal_stable;
   logic external_gen_enable, external_stable;
   logic next_irq_en, next_fail, next_mon_on, next_sel;
   logic next_int_on, next_int_stb, next_ext_on, next_ext_stb;
   logic fail_armed;
   logic [`CGC_CNT_W-1:0] ext_count;
   logic ext_count_done;
   logic stop_off, int_gone, ext_gone;
   logic wr_ctrl, tune_wr, mult_wr, trim_wr, slow_wr;
   cgc_byte_t w;

   assign w = reg_wdata;
   assign stop_off = stop_mode & ~keep_running_in_stop;
   // The monitor only reports dead clocks while it is on
   assign int_gone = monitor_on & internal_dead;
   assign ext_gone = monitor_on & external_dead;
   assign wr_ctrl = reg_wr & (reg_addr == `CGC_ADDR_CTRL);
   assign tune_wr = reg_wr & ~monitor_on;
   assign mult_wr = tune_wr & (reg_addr == `CGC_ADDR_MULT);
   assign trim_wr = tune_wr & (reg_addr == `CGC_ADDR_TRIM);
   assign slow_wr = tune_wr & ~internal_gen_enable;
   // Crystal start-up needs the long count; driven clocks need the short count of 16
   assign ext_count_done = crystal_option ?
      (ext_count >= `CGC_CNT_W'(STARTUP_COUNT)) :
      (ext_count >= `CGC_CNT_W'(`CGC_EXT_STARTUP));

   // Forced values come first in each chain so writes lose to them
   always_comb begin
      next_mon_on = monitor_on;
      if (!internal_gen_enable || !external_gen_enable || stop_off) begin
         next_mon_on = 1'b0;
      end else if (monitor_fail_flag || int_gone || ext_gone) begin
         // A flag being set this cycle must not see the monitor drop
         next_mon_on = 1'b1;
      end else if (wr_ctrl) begin
         if (w[`CGC_BIT_MON_ON]) begin
            if (internal_stable && external_stable) begin
               next_mon_on = 1'b1;
            end
         end else begin
            next_mon_on = 1'b0;
         end
      end
   end

   always_comb begin
      next_fail = monitor_fail_flag;
      // Monitor going off this cycle takes the flag with it
      if (!monitor_on || !next_mon_on) begin
         next_fail = 1'b0;
      end else if (int_gone || ext_gone) begin
         next_fail = 1'b1;
      end else if (wr_ctrl && !w[`CGC_BIT_FAIL] && fail_armed) begin
         next_fail = 1'b0;
      end
   end

   always_comb begin
      next_irq_en = monitor_irq_enable;
      if (!monitor_on || !next_mon_on) begin
         next_irq_en = 1'b0;
      end else if (wr_ctrl) begin
         next_irq_en = w[`CGC_BIT_IRQ_EN];
      end
   end

   always_comb begin
      next_sel = clock_select;
      if (int_gone || !internal_gen_enable) begin
         next_sel = 1'b1;
      end else if (ext_gone || !external_gen_enable) begin
         next_sel = 1'b0;
      end else if (wr_ctrl) begin
         if (w[`CGC_BIT_SEL] && external_stable) begin
            next_sel = 1'b1;
         end else if (!w[`CGC_BIT_SEL] && internal_stable) begin
            next_sel = 1'b0;
         end
      end
   end

   always_comb begin
      next_int_on = internal_gen_enable;
      if (monitor_on || !clock_select) begin
         next_int_on = 1'b1;
      end else if (wr_ctrl) begin
         next_int_on = w[`CGC_BIT_INT_ON];
      end
   end

   always_comb begin
      next_ext_on = external_gen_enable;
      if (!external_input_option) begin
         next_ext_on = 1'b0;
      end else if (monitor_on || clock_select) begin
         next_ext_on = 1'b1;
      end else if (wr_ctrl) begin
         next_ext_on = w[`CGC_BIT_EXT_ON];
      end
   end

   always_comb begin
      next_int_stb = internal_lock;
      if (int_gone || !internal_gen_enable || mult_wr || trim_wr ||
          stop_off) begin
         next_int_stb = 1'b0;
      end
   end

   always_comb begin
      next_ext_stb = ext_count_done;
      if (ext_gone || !external_gen_enable || stop_off) begin
         next_ext_stb = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         monitor_irq_enable <= 1'b0;
         monitor_fail_flag <= 1'b0;
         monitor_on <= 1'b0;
         clock_select <= 1'b0;
         internal_gen_enable <= 1'b1;
         internal_stable <= 1'b0;
         external_gen_enable <= 1'b0;
         external_stable <= 1'b0;
      end else if (clk_en) begin
         monitor_irq_enable <= next_irq_en;
         monitor_fail_flag <= next_fail;
         monitor_on <= next_mon_on;
         clock_select <= next_sel;
         internal_gen_enable <= next_int_on;
         internal_stable <= next_int_stb;
         external_gen_enable <= next_ext_on;
         external_stable <= next_ext_stb;
      end
   end

   // Flag clear is armed by a control read that saw the flag set
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         fail_armed <= 1'b0;
      end else if (clk_en) begin
         if (!next_fail) begin
            fail_armed <= 1'b0;
         end else if (reg_rd && reg_addr == `CGC_ADDR_CTRL &&
                      monitor_fail_flag) begin
            fail_armed <= 1'b1;
         end
      end
   end

   // Counter saturates; restarts whenever the external path drops
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         ext_count <= '0;
      end else if (clk_en) begin
         if (!external_gen_enable || ext_gone || stop_off) begin
            ext_count <= '0;
         end else if (external_clock_tick && !ext_count_done) begin
            ext_count <= ext_count + `CGC_CNT_W'(1);
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         multiplier_register <= `CGC_RST_MULT;
         capacitor_adjust_register <= `CGC_RST_TRIM;
      end else if (clk_en) begin
         if (mult_wr) begin
            multiplier_register <= w[6:0];
         end
         if (trim_wr) begin
            capacitor_adjust_register <= w;
         end
      end
   end

   // The loop filter owns these while the internal generator runs
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         oscillator_halving_count <= `CGC_RST_HALV;
         oscillator_stage_count <= `CGC_RST_STAGE;
      end else if (clk_en) begin
         if (internal_gen_enable) begin
            oscillator_halving_count <= loop_halving;
            oscillator_stage_count <= loop_stage;
         end else begin
            if (slow_wr && reg_addr == `CGC_ADDR_HALV) begin
               oscillator_halving_count <= w[3:0];
            end
            if (slow_wr && reg_addr == `CGC_ADDR_STAGE) begin
               oscillator_stage_count <= w;
            end
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         monitor_irq <= 1'b0;
         oscillator_src_ext <= 1'b0;
         internal_gen_on <= 1'b1;
         external_gen_on <= 1'b0;
         osc_pin_active <= 1'b0;
      end else if (clk_en) begin
         monitor_irq <= next_irq_en & next_fail;
         oscillator_src_ext <= next_sel;
         internal_gen_on <= next_int_on;
         external_gen_on <= next_ext_on;
         osc_pin_active <= external_input_option & next_ext_on;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         reg_rdata <= '0;
      end else if (clk_en) begin
         if (reg_rd) begin
            unique case (reg_addr)
               `CGC_ADDR_CTRL: reg_rdata <= {monitor_irq_enable,
                  monitor_fail_flag, monitor_on, clock_select,
                  internal_gen_enable, internal_stable,
                  external_gen_enable, external_stable};
               `CGC_ADDR_MULT: reg_rdata <= {1'b0, multiplier_register};
               `CGC_ADDR_TRIM: reg_rdata <= capacitor_adjust_register;
               `CGC_ADDR_HALV: reg_rdata <= {4'h0, oscillator_halving_count};
               `CGC_ADDR_STAGE: reg_rdata <= oscillator_stage_count;
               default: reg_rdata <= '0;
            endcase
         end else begin
            reg_rdata <= '0;
         end
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b);

   chk_irq_pair: assert property (clk_en |=>
      monitor_irq == (monitor_irq_enable & monitor_fail_flag))
      else $error("irq does not match enable and flag");
   chk_irq_en_off: assert property (!monitor_on |-> !monitor_irq_enable)
      else $error("irq enable set while monitor off");
   chk_fail_sets: assert property (clk_en && monitor_on && !stop_off &&
      internal_gen_enable && external_gen_enable && internal_dead
      |=> monitor_fail_flag)
      else $error("dead clock did not set flag");
   chk_fail_clear: assert property (clk_en && wr_ctrl &&
      !w[`CGC_BIT_FAIL] && !fail_armed && monitor_fail_flag && !stop_off
      && internal_gen_enable && external_gen_enable
      |=> monitor_fail_flag)
      else $error("flag cleared without prior read");
   chk_mon_gate: assert property (clk_en && $rose(monitor_on) |->
      $past(internal_stable) && $past(external_stable))
      else $error("monitor turned on while not stable");
   chk_mon_hold: assert property (clk_en && monitor_fail_flag &&
      internal_gen_enable && external_gen_enable && !stop_off
      |=> monitor_on)
      else $error("monitor dropped with flag set");
   chk_mon_off: assert property (clk_en && stop_off |=> !monitor_on)
      else $error("monitor on during stop");
   chk_sel_out: assert property (oscillator_src_ext == clock_select)
      else $error("source select output mismatch");
   chk_sel_force: assert property (clk_en && !internal_gen_enable
      |=> clock_select)
      else $error("select not forced external");
   chk_int_force: assert property (clk_en && !clock_select
      |=> internal_gen_enable)
      else $error("internal enable not forced on");
   chk_trim_stb: assert property (clk_en && trim_wr
      |=> !internal_stable)
      else $error("trim write kept internal stable");
   chk_ext_opt: assert property (clk_en && !external_input_option
      |=> !external_gen_enable && !osc_pin_active)
      else $error("external enabled without option");

   cov_fail_irq: cover property (monitor_irq);
   cov_switch_ext: cover property (!clock_select ##1 clock_select);
   cov_fail_clear: cover property (monitor_fail_flag ##1
      !monitor_fail_flag);
endmodule

//--- hw/cgc_consts.svh
// Constants for the clock generator control block
`ifndef CGC_CONSTS_SVH
`define CGC_CONSTS_SVH
`define CGC_ADDR_CTRL 3'h0
`define CGC_ADDR_MULT 3'h1
`define CGC_ADDR_TRIM 3'h2
`define CGC_ADDR_HALV 3'h3
`define CGC_ADDR_STAGE 3'h4
`define CGC_BIT_IRQ_EN 7
`define CGC_BIT_FAIL 6
`define CGC_BIT_MON_ON 5
`define CGC_BIT_SEL 4
`define CGC_BIT_INT_ON 3
`define CGC_BIT_INT_STB 2
`define CGC_BIT_EXT_ON 1
`define CGC_BIT_EXT_STB 0
`define CGC_RST_MULT 7'h15
`define CGC_RST_TRIM 8'h80
`define CGC_RST_HALV 4'h0
`define CGC_RST_STAGE 8'h00
`define CGC_XTAL_STARTUP 4096
`define CGC_EXT_STARTUP 16
`define CGC_CNT_W 13
`endif

//--- hw/cgc_pkg.sv
// Types shared by the clock generator control block
package cgc_pkg;
   typedef logic [2:0] cgc_addr_t;
   typedef logic [7:0] cgc_byte_t;
endpackage

//--- verification/test_clock_gen_control_interlocks.sv
// Self-checking bench for the clock generator control block
`timescale 1ns/1ps
module test_clock_gen_control_interlocks;
   import cgc_pkg::*;
   typedef struct {
      logic w;
      cgc_addr_t a;
      cgc_byte_t d;
      cgc_byte_t e;
   } cgc_row_t;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic clk_en = 1'b1;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic stop_mode = 1'b0;
   logic keep_running_in_stop = 1'b0;
   logic external_input_option = 1'b0;
   logic crystal_option = 1'b0;
   logic internal_dead = 1'b0;
   logic external_dead = 1'b0;
   logic internal_lock = 1'b0;
   logic external_clock_tick = 1'b0;
   cgc_addr_t reg_addr = 3'h0;
   cgc_byte_t reg_wdata = 8'h00;
   cgc_byte_t loop_stage = 8'h3c;
   logic [3:0] loop_halving = 4'h6;
   cgc_byte_t reg_rdata, capacitor_adjust_register, oscillator_stage_count;
   logic [6:0] multiplier_register;
   logic [3:0] oscillator_halving_count;
   logic monitor_irq, oscillator_src_ext, internal_gen_on, external_gen_on;
   logic osc_pin_active;
   int miscompares = 0;
   int check_count = 0;
   cgc_row_t rows[11];

   always #4 sys_clk = ~sys_clk;

   // Short start-up count keeps the crystal path quick to reach
   cgc_control #(.STARTUP_COUNT(32)) u_cgc_control (.sys_clk, .rst_b,
      .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .stop_mode, .keep_running_in_stop, .external_input_option,
      .crystal_option, .internal_dead, .external_dead, .internal_lock,
      .external_clock_tick, .loop_halving, .loop_stage, .monitor_irq,
      .oscillator_src_ext, .internal_gen_on, .external_gen_on,
      .osc_pin_active, .multiplier_register, .capacitor_adjust_register,
      .oscillator_halving_count, .oscillator_stage_count);

   task automatic chk_byte(input cgc_byte_t got, input cgc_byte_t exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t byte got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t bit got %b exp %b", $time, got, exp);
      end
   endtask

   task automatic wr(input cgc_addr_t a, input cgc_byte_t d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   // Read data stand for one cycle only, so sample just after the edge
   task automatic rd(input cgc_addr_t a, input cgc_byte_t e,
                     input cgc_byte_t m);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk_byte(reg_rdata & m, e);
   endtask

   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge sys_clk);
         external_clock_tick <= 1'b1;
         @(posedge sys_clk);
         external_clock_tick <= 1'b0;
      end
   endtask

   task automatic do_reset();
      @(posedge sys_clk);
      rst_b <= 1'b0;
      repeat (16) @(posedge sys_clk);
      rst_b <= 1'b1;
   endtask

   task automatic wrap_up();
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge sys_clk);
      miscompares++;
      wrap_up();
   end

   initial begin
      rows = '{'{1'b0, 3'h0, 8'h00, 8'h08}, '{1'b0, 3'h1, 8'h00, 8'h15},
               '{1'b0, 3'h2, 8'h00, 8'h80}, '{1'b0, 3'h3, 8'h00, 8'h06},
               '{1'b0, 3'h5, 8'h00, 8'h00}, '{1'b1, 3'h1, 8'h2a, 8'h2a},
               '{1'b1, 3'h2, 8'h5a, 8'h5a}, '{1'b1, 3'h3, 8'h0f, 8'h06},
               '{1'b1, 3'h4, 8'h77, 8'h3c}, '{1'b1, 3'h6, 8'hff, 8'h00},
               '{1'b1, 3'h0, 8'h30, 8'h08}};
      do_reset();
      foreach (rows[i]) begin
         if (rows[i].w) wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].e, 8'hff);
      end
      chk_byte({4'h0, oscillator_halving_count}, 8'h06);
      chk_byte(oscillator_stage_count, 8'h3c);
      internal_lock <= 1'b1;
      repeat (3) @(posedge sys_clk);
      // Write then read back to back to catch the one-cycle clear
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= 3'h1;
      reg_wdata <= 8'h2a;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      reg_addr <= 3'h0;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk_byte(reg_rdata, 8'h08);
      rd(3'h0, 8'h0c, 8'hff);
      wr(3'h0, 8'h2a);
      rd(3'h0, 8'h0c, 8'hff);
      chk_bit(osc_pin_active, 1'b0);
      external_input_option <= 1'b1;
      for (int t = 16; t <= 32; t += 16) begin
         crystal_option <= (t == 32);
         wr(3'h0, 8'h0a);
         ticks(t - 1);
         wr(3'h0, 8'h1a);
         rd(3'h0, 8'h0e, 8'hff);
         ticks(1);
         rd(3'h0, 8'h0f, 8'hff);
         chk_bit(osc_pin_active, 1'b1);
         if (t == 16) begin
            wr(3'h0, 8'h08);
            rd(3'h0, 8'h0c, 8'hff);
         end
      end
      wr(3'h0, 8'h1a);
      rd(3'h0, 8'h1f, 8'hff);
      chk_bit(oscillator_src_ext, 1'b1);
      wr(3'h0, 8'h18);
      rd(3'h0, 8'h1f, 8'hff);
      wr(3'h0, 8'hba);
      rd(3'h0, 8'h3f, 8'hff);
      wr(3'h0, 8'hba);
      rd(3'h0, 8'hbf, 8'hff);
      chk_bit(monitor_irq, 1'b0);
      @(posedge sys_clk);
      external_dead <= 1'b1;
      @(posedge sys_clk);
      external_dead <= 1'b0;
      repeat (3) @(posedge sys_clk);
      #1;
      chk_bit(monitor_irq, 1'b1);
      chk_bit(oscillator_src_ext, 1'b0);
      // Flag not yet seen by a read, so this write must not clear it
      wr(3'h0, 8'h8a);
      repeat (2) @(posedge sys_clk);
      #1;
      chk_bit(monitor_irq, 1'b1);
      rd(3'h0, 8'hee, 8'hfe);
      wr(3'h1, 8'h11);
      rd(3'h1, 8'h2a, 8'hff);
      wr(3'h0, 8'h2a);
      repeat (2) @(posedge sys_clk);
      #1;
      chk_bit(monitor_irq, 1'b0);
      rd(3'h0, 8'h2e, 8'hfe);
      @(posedge sys_clk);
      internal_dead <= 1'b1;
      @(posedge sys_clk);
      internal_dead <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
      chk_bit(oscillator_src_ext, 1'b1);
      rd(3'h0, 8'h7e, 8'hff);
      @(posedge sys_clk);
      stop_mode <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rd(3'h0, 8'h1a, 8'hff);
      stop_mode <= 1'b0;
      ticks(32);
      // Back to the internal source before touching the internal enable
      wr(3'h0, 8'h0a);
      wr(3'h0, 8'h02);
      rd(3'h0, 8'h0f, 8'hff);
      wr(3'h0, 8'h1a);
      wr(3'h0, 8'h12);
      rd(3'h0, 8'h13, 8'hff);
      chk_bit(internal_gen_on, 1'b0);
      wr(3'h3, 8'h05);
      wr(3'h4, 8'h77);
      rd(3'h3, 8'h05, 8'hff);
      rd(3'h4, 8'h77, 8'hff);
      chk_byte(oscillator_stage_count, 8'h77);
      wr(3'h0, 8'h00);
      rd(3'h0, 8'h13, 8'hff);
      chk_bit(oscillator_src_ext, 1'b1);
      do_reset();
      rd(3'h0, 8'h0c, 8'hff);
      rd(3'h1, 8'h15, 8'hff);
      rd(3'h2, 8'h80, 8'hff);
      chk_bit(external_gen_on, 1'b0);
      chk_bit(internal_gen_on, 1'b1);
      chk_byte({1'b0, multiplier_register}, 8'h15);
      chk_byte(capacitor_adjust_register, 8'h80);
      // With the enable low the write below must leave no trace
      clk_en <= 1'b0;
      wr(3'h2, 8'h33);
      clk_en <= 1'b1;
      rd(3'h2, 8'h80, 8'hff);
      chk_byte(capacitor_adjust_register, 8'h80);
      wrap_up();
   end
endmodule
